// *** design/pac_decoder.v ***
// Binary command frame decoder for axis and global parameter access
//
// Summary of operation
// - Instruction 6 reads axis parameter, motor 0.
// - Axis read replies OK with value read.
// - Instruction 9 writes global parameter, banks 0/2/3.
// - Bank 0 general, 2 user, 3 interrupt.
// - Bank 0 writes also go to nonvolatile.
// - Instruction 10 reads global parameter, replies value.
// - Instruction 11 stores user variable, replies OK.
// - Instruction 12 reloads user variable, replies OK.
// - User variables reloaded after power-up.
// - Serial address is bank 0 parameter 66.
// - Axis parameter 1 is actual position.
// - Accumulator updated only in standalone mode.
// - OK status is 64h after two addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pac_consts.vh"

module pac_decoder
(
   input  wire         REF_CLK,
   input  wire         RST_N,
   input  wire         RX_VALID,
   input  wire [7:0]   RX_BYTE,
   output reg          RX_READY,
   output reg          TX_VALID,
   output reg  [7:0]   TX_BYTE,
   input  wire         STANDALONE,
   input  wire [31:0]  ACT_POS,
   input  wire [31:0]  AXIS_DATA,
   output reg  [7:0]   AXIS_SEL,
   output reg  [31:0]  ACCU,
   output reg  [7:0]   SER_ADDR
);

   localparam [5:0] S_INIT_RD = 6'h01;
   localparam [5:0] S_INIT_WR = 6'h02;
   localparam [5:0] S_RX      = 6'h04;
   localparam [5:0] S_DEC     = 6'h08;
   localparam [5:0] S_RD      = 6'h10;
   localparam [5:0] S_TX      = 6'h20;

   reg                rst_meta_ff;
   reg                rst_sync_n_ff;
   reg  [5:0]         state_ff;
   reg  [63:0]        frame_ff;
   reg  [7:0]         sum_ff;
   reg  [3:0]         idx_ff;
   reg  [7:0]         init_cnt_ff;
   reg  [7:0]         st_ff;
   reg  [31:0]        val_ff;
   reg  [7:0]         tx_sum_ff;

   reg                ram_we;
   reg  [`PAC_AW-1:0] ram_addr;
   reg  [`PAC_DW-1:0] ram_wd;
   reg                nv_we;
   reg  [`PAC_AW-1:0] nv_addr;
   reg  [`PAC_DW-1:0] nv_wd;
   wire [`PAC_DW-1:0] ram_rd;
   wire [`PAC_DW-1:0] nv_rd;

   wire [7:0]         f_addr  = frame_ff[63:56];
   wire [7:0]         f_op    = frame_ff[55:48];
   wire [7:0]         f_type  = frame_ff[47:40];
   wire [7:0]         f_bank  = frame_ff[39:32];
   wire [31:0]        f_value = frame_ff[31:0];

   // Serial address read from its own register, not the store
   wire [31:0]        glob_rd = (f_bank == `PAC_BANK_GEN && f_type == `PAC_PAR_SER_ADDR) ?
                                {24'h000000, SER_ADDR} : ram_rd;

   function bank_ok;
      input [7:0] bank;
      begin
         bank_ok = (bank == `PAC_BANK_GEN) || (bank == `PAC_BANK_USER) || (bank == `PAC_BANK_IRQ);
      end
   endfunction

   // Bank number picks a 256-word region
   function [`PAC_AW-1:0] par_addr;
      input [7:0] bank;
      input [7:0] ptype;
      begin
         par_addr = {bank[1:0], ptype};
      end
   endfunction

   // Reply byte for a given position; checksum handled apart
   function [7:0] reply_byte;
      input [3:0]  idx;
      input [7:0]  addr;
      input [7:0]  st;
      input [7:0]  op;
      input [31:0] val;
      begin
         case (idx)
            `PAC_IDX_HOST: reply_byte = `PAC_HOST_ADDR;
            `PAC_IDX_ADDR: reply_byte = addr;
            `PAC_IDX_ST:   reply_byte = st;
            `PAC_IDX_OP:   reply_byte = op;
            `PAC_IDX_V3:   reply_byte = val[31:24];
            `PAC_IDX_V2:   reply_byte = val[23:16];
            `PAC_IDX_V1:   reply_byte = val[15:8];
            `PAC_IDX_V0:   reply_byte = val[7:0];
            default:       reply_byte = 8'h00;
         endcase
      end
   endfunction

   // Reset released through two flops
   always @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_meta_ff   <= 1'b0;
         rst_sync_n_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff   <= 1'b1;
         rst_sync_n_ff <= rst_meta_ff;
      end
   end

   // Memory port steering
   always @*
   begin
      ram_we   = 1'b0;
      ram_addr = par_addr(f_bank, f_type);
      ram_wd   = f_value;
      nv_we    = 1'b0;
      nv_addr  = par_addr(f_bank, f_type);
      nv_wd    = f_value;
      case (state_ff)
         S_INIT_RD:
         begin
            nv_addr = {`PAC_USER_SEL, init_cnt_ff};
         end
         S_INIT_WR:
         begin
            ram_we   = 1'b1;
            ram_addr = {`PAC_USER_SEL, init_cnt_ff};
            ram_wd   = nv_rd;
         end
         S_DEC:
         begin
            if (f_op == `PAC_OP_SET_GLOB && bank_ok(f_bank))
            begin
               ram_we = 1'b1;
               nv_we  = (f_bank == `PAC_BANK_GEN);
            end
         end
         S_RD:
         begin
            if (f_op == `PAC_OP_STORE_GLOB)
            begin
               nv_we = 1'b1;
               nv_wd = ram_rd;
            end
            else if (f_op == `PAC_OP_RESTORE_GLOB)
            begin
               ram_we = 1'b1;
               ram_wd = nv_rd;
            end
         end
         default:
         begin
            ram_we = 1'b0;
         end
      endcase
   end

   pac_mem u_work_mem
   (
      .clk      (REF_CLK),
      .we       (ram_we),
      .addr     (ram_addr),
      .wdata    (ram_wd),
      .rdata_ff (ram_rd)
   );

   pac_mem u_nv_mem
   (
      .clk      (REF_CLK),
      .we       (nv_we),
      .addr     (nv_addr),
      .wdata    (nv_wd),
      .rdata_ff (nv_rd)
   );

   always @(posedge REF_CLK or negedge rst_sync_n_ff)
   begin
      if (!rst_sync_n_ff)
      begin
         state_ff    <= S_INIT_RD;
         frame_ff    <= 64'h0000000000000000;
         sum_ff      <= 8'h00;
         idx_ff      <= 4'h0;
         init_cnt_ff <= 8'h00;
         st_ff       <= 8'h00;
         val_ff      <= 32'h00000000;
         tx_sum_ff   <= 8'h00;
         RX_READY    <= 1'b0;
         TX_VALID    <= 1'b0;
         TX_BYTE     <= 8'h00;
         AXIS_SEL    <= 8'h00;
         ACCU        <= 32'h00000000;
         SER_ADDR    <= `PAC_ADDR_RST;
      end
      else
      begin
         TX_VALID <= 1'b0;
         case (state_ff)
            S_INIT_RD:
            begin
               state_ff <= S_INIT_WR;
            end
            S_INIT_WR:
            begin
               init_cnt_ff <= init_cnt_ff + 8'h01;
               if (init_cnt_ff == `PAC_USER_LAST)
               begin
                  state_ff <= S_RX;
                  RX_READY <= 1'b1;
               end
               else
               begin
                  state_ff <= S_INIT_RD;
               end
            end
            S_RX:
            begin
               if (RX_VALID)
               begin
                  if (idx_ff == `PAC_FRAME_LAST)
                  begin
                     idx_ff <= 4'h0;
                     sum_ff <= 8'h00;
                     if (RX_BYTE == sum_ff && f_addr == SER_ADDR)
                     begin
                        state_ff <= S_DEC;
                        RX_READY <= 1'b0;
                     end
                  end
                  else
                  begin
                     // Bytes shift in, value MSB first
                     frame_ff <= {frame_ff[55:0], RX_BYTE};
                     sum_ff   <= sum_ff + RX_BYTE;
                     idx_ff   <= idx_ff + 4'h1;
                     if (idx_ff == `PAC_IDX_TYPE)
                     begin
                        AXIS_SEL <= RX_BYTE;
                     end
                  end
               end
            end
            S_DEC:
            begin
               state_ff <= S_TX;
               st_ff    <= `PAC_ST_OK;
               val_ff   <= 32'h00000000;
               case (f_op)
                  `PAC_OP_GET_AXIS:
                  begin
                     if (f_bank != `PAC_AXIS_MOTOR)
                     begin
                        st_ff <= `PAC_ST_BAD_VAL;
                     end
                     else
                     begin
                        val_ff <= (f_type == `PAC_AXIS_ACT_POS) ? ACT_POS : AXIS_DATA;
                        if (STANDALONE)
                        begin
                           ACCU <= (f_type == `PAC_AXIS_ACT_POS) ? ACT_POS : AXIS_DATA;
                        end
                     end
                  end
                  `PAC_OP_SET_GLOB:
                  begin
                     if (!bank_ok(f_bank))
                     begin
                        st_ff <= `PAC_ST_BAD_VAL;
                     end
                     else if (f_bank == `PAC_BANK_GEN && f_type == `PAC_PAR_SER_ADDR)
                     begin
                        SER_ADDR <= f_value[7:0];
                     end
                  end
                  `PAC_OP_GET_GLOB:
                  begin
                     if (bank_ok(f_bank))
                     begin
                        state_ff <= S_RD;
                     end
                     else
                     begin
                        st_ff <= `PAC_ST_BAD_VAL;
                     end
                  end
                  `PAC_OP_STORE_GLOB, `PAC_OP_RESTORE_GLOB:
                  begin
                     if (f_bank == `PAC_BANK_USER)
                     begin
                        state_ff <= S_RD;
                     end
                     else
                     begin
                        st_ff <= `PAC_ST_BAD_VAL;
                     end
                  end
                  default:
                  begin
                     st_ff <= `PAC_ST_BAD_CMD;
                  end
               endcase
            end
            S_RD:
            begin
               state_ff <= S_TX;
               if (f_op == `PAC_OP_GET_GLOB)
               begin
                  val_ff <= glob_rd;
                  if (STANDALONE)
                  begin
                     ACCU <= glob_rd;
                  end
               end
            end
            S_TX:
            begin
               TX_VALID <= 1'b1;
               if (idx_ff == `PAC_FRAME_LAST)
               begin
                  TX_BYTE   <= tx_sum_ff;
                  tx_sum_ff <= 8'h00;
                  idx_ff    <= 4'h0;
                  state_ff  <= S_RX;
                  RX_READY  <= 1'b1;
               end
               else
               begin
                  TX_BYTE   <= reply_byte(idx_ff, f_addr, st_ff, f_op, val_ff);
                  tx_sum_ff <= tx_sum_ff + reply_byte(idx_ff, f_addr, st_ff, f_op, val_ff);
                  idx_ff    <= idx_ff + 4'h1;
               end
            end
            default:
            begin
               state_ff <= S_RX;
               RX_READY <= 1'b1;
            end
         endcase
      end
   end

endmodule // pac_decoder

`default_nettype wire

// *** design/pac_consts.vh ***
// Constants for the parameter access command decoder
`ifndef PAC_CONSTS_VH
`define PAC_CONSTS_VH

// Instruction codes
`define PAC_OP_GET_AXIS      8'h06
`define PAC_OP_SET_GLOB      8'h09
`define PAC_OP_GET_GLOB      8'h0A
`define PAC_OP_STORE_GLOB    8'h0B
`define PAC_OP_RESTORE_GLOB  8'h0C

// Global parameter banks
`define PAC_BANK_GEN         8'h00
`define PAC_BANK_USER        8'h02
`define PAC_BANK_IRQ         8'h03

// Parameter numbers
`define PAC_PAR_SER_ADDR     8'h42
`define PAC_AXIS_ACT_POS     8'h01
`define PAC_AXIS_MOTOR       8'h00

// Reply status codes and addresses
`define PAC_ST_OK            8'h64
`define PAC_ST_BAD_CMD       8'h02
`define PAC_ST_BAD_VAL       8'h04
`define PAC_HOST_ADDR        8'h02
`define PAC_ADDR_RST         8'h01

// Frame layout: 8 payload bytes, then checksum at index 8
`define PAC_FRAME_LAST       4'h8
`define PAC_IDX_TYPE         4'h2
`define PAC_IDX_ST           4'h2
`define PAC_IDX_OP           4'h3
`define PAC_IDX_V3           4'h4
`define PAC_IDX_V2           4'h5
`define PAC_IDX_V1           4'h6
`define PAC_IDX_V0           4'h7
`define PAC_IDX_ADDR         4'h1
`define PAC_IDX_HOST         4'h0

// User bank restore walk
`define PAC_USER_LAST        8'hFF
`define PAC_USER_SEL         2'h2

// Memory geometry
`define PAC_AW               10
`define PAC_DW               32

`endif

// *** design/pac_mem.v ***
// Single-port parameter memory with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "pac_consts.vh"

module pac_mem
(
   input  wire                clk,
   input  wire                we,
   input  wire [`PAC_AW-1:0]  addr,
   input  wire [`PAC_DW-1:0]  wdata,
   output reg  [`PAC_DW-1:0]  rdata_ff
);

   reg [`PAC_DW-1:0] mem [0:(1<<`PAC_AW)-1];

   // Read returns old contents on a same-cycle write
   always @(posedge clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata_ff <= mem[addr];
   end

endmodule // pac_mem

`default_nettype wire

// *** sim/pac_decoder_sva.sv ***
// Port-level checker for the command decoder
`timescale 1ns/1ns
`default_nettype none
module pac_decoder_sva
(
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        RX_READY,
   input wire logic        TX_VALID,
   input wire logic [7:0]  TX_BYTE,
   input wire logic        STANDALONE,
   input wire logic [31:0] ACCU,
   input wire logic [7:0]  SER_ADDR
);
   logic [3:0] idx_ff;
   logic [7:0] sum_ff;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // Byte index and running sum of the reply
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N || !TX_VALID)
      begin
         idx_ff <= 4'h0;
         sum_ff <= 8'h00;
      end
      else
      begin
         idx_ff <= idx_ff + 4'h1;
         sum_ff <= sum_ff + TX_BYTE;
      end
   end
   a_reply_nine_bytes: assert property ($rose(TX_VALID) |-> TX_VALID [*8] ##1 TX_VALID ##1 !TX_VALID)
      else $error("reply not nine bytes");
   a_reply_host_byte: assert property (TX_VALID && idx_ff == 4'h0 |-> TX_BYTE == 8'h02)
      else $error("reply host byte wrong");
   a_reply_checksum: assert property (TX_VALID && idx_ff == 4'h8 |-> TX_BYTE == sum_ff)
      else $error("reply checksum wrong");
   a_reply_soon: assert property ($fell(RX_READY) |-> ##[2:5] TX_VALID)
      else $error("no reply after frame");
   a_ready_after_reply: assert property ($fell(TX_VALID) |-> RX_READY)
      else $error("not ready after reply");
   a_no_tx_when_ready: assert property (TX_VALID |-> RX_READY == (idx_ff == 4'h8))
      else $error("reply while ready");
   a_tx_byte_hold: assert property (!TX_VALID |-> $stable(TX_BYTE))
      else $error("idle reply byte moved");
   a_direct_accu_kept: assert property (!STANDALONE && !$past(STANDALONE) |-> $stable(ACCU))
      else $error("accumulator moved in direct mode");
   a_addr_busy_only: assert property ($changed(SER_ADDR) |-> !RX_READY)
      else $error("address changed outside command");
endmodule // pac_decoder_sva
bind pac_decoder pac_decoder_sva u_sva
(
   .REF_CLK    (REF_CLK),
   .RST_N      (RST_N),
   .RX_READY   (RX_READY),
   .TX_VALID   (TX_VALID),
   .TX_BYTE    (TX_BYTE),
   .STANDALONE (STANDALONE),
   .ACCU       (ACCU),
   .SER_ADDR   (SER_ADDR)
);
`default_nettype wire

// *** sim/pac_host.sv ***
// Host controller model: sends command frames, collects replies
`timescale 1ns/1ns
`default_nettype none
module pac_host
(
   input wire logic        clk,
   input wire logic        rx_ready,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_byte,
   output var logic        rx_valid,
   output var logic [7:0]  rx_byte
);
   logic hang = 1'b0;
   logic [15:0] echo = 16'h0000;
   initial
   begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end
   task automatic xfer(input logic [7:0] ad, op, ty, bk, input logic [31:0] v, input logic bad,
                       output logic got, output logic [7:0] st, output logic [31:0] rv);
      logic [7:0] f [0:8];
      logic [7:0] r [0:8];
      int n;
      got = 1'b0;
      st = 8'h00;
      rv = 32'h0;
      {f[0], f[1], f[2], f[3]} = {ad, op, ty, bk};
      {f[4], f[5], f[6], f[7]} = v;
      // byte sum, broken only on request
      f[8] = ad + op + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0] + {7'h00, bad};
      for (int i = 0; i < 9; i++)
      begin
         rx_valid <= 1'b1;
         rx_byte <= f[i];
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (rx_ready !== 1'b1 && n < 1200);
         if (n >= 1200)
            hang = 1'b1;
      end
      // Released line shows inverse, not a stale byte
      rx_valid <= 1'b0;
      rx_byte <= ~f[8];
      for (n = 0; n < 12 && !got; n++)
      begin
         @(posedge clk);
         got = (tx_valid === 1'b1);
      end
      if (got)
      begin
         r[0] = tx_byte;
         for (int i = 1; i < 9; i++)
         begin
            @(posedge clk);
            r[i] = tx_byte;
         end
         st = r[2];
         rv = {r[4], r[5], r[6], r[7]};
         echo = {r[1], r[3]};
      end
   endtask
endmodule // pac_host
`default_nettype wire

// *** sim/pac_decoder_tb_top.sv ***
// Self-checking bench for the command decoder
`timescale 1ns/1ns
`default_nettype none
module pac_decoder_tb_top;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        standalone = 1'b0;
   logic [31:0] act_pos = 32'h0;
   logic [31:0] axis_data = 32'h0;
   wire logic   rx_valid, rx_ready, tx_valid;
   wire logic [7:0]  rx_byte, tx_byte, axis_sel, ser_addr;
   wire logic [31:0] accu;
   int          err_count = 0;
   int          n_compared = 0;
   logic [31:0] seed = 32'h00000020;
   logic        g;
   logic [7:0]  last_ad, last_op;
   logic [7:0]  st, ty, bk;
   logic [31:0] rv, v;
   always #2 ref_clk = ~ref_clk;
   pac_decoder DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
      .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .STANDALONE(standalone),
      .ACT_POS(act_pos), .AXIS_DATA(axis_data), .AXIS_SEL(axis_sel), .ACCU(accu), .SER_ADDR(ser_addr));
   pac_host host (.clk(ref_clk), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .rx_valid(rx_valid), .rx_byte(rx_byte));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (err_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] ad, op, t, b, input logic [31:0] val, input logic bad);
      last_ad = ad;
      last_op = op;
      host.xfer(ad, op, t, b, val, bad, g, st, rv);
      if (host.hang)
      begin
         err_count++;
         give_verdict();
      end
   endtask
   task automatic ok(input logic [31:0] exp, input logic use_val);
      check("reply", {31'h0, g}, 32'h1);
      check("status", {24'h0, st}, 32'h64);
      check("echo", {16'h0, host.echo}, {16'h0, last_ad, last_op});
      if (use_val)
         check("value", rv, exp);
   endtask
   task automatic do_reset();
      int w;
      rst_n <= 1'b0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (w = 0; w < 1200 && rx_ready !== 1'b1; w++)
         @(posedge ref_clk);
      check("ready", {31'h0, rx_ready}, 32'h1);
      if (rx_ready !== 1'b1)
         give_verdict();
   endtask
   initial
   begin
      do_reset();
      cmd(8'h01, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0);
      ok(32'h1, 1'b1);
      standalone <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         v = rnd();
         bk = (i % 3 == 0) ? 8'h00 : 8'h01 + 8'(i % 3);
         ty = (v[15:8] == 8'h42) ? 8'h43 : v[15:8];
         cmd(8'h01, 8'h09, ty, bk, v, 1'b0);
         ok(32'h0, 1'b0);
         cmd(8'h01, 8'h0A, ty, bk, rnd(), 1'b0);
         ok(v, 1'b1);
         check("accu", accu, v);
      end
      act_pos <= rnd();
      axis_data <= rnd();
      @(posedge ref_clk);
      cmd(8'h01, 8'h06, 8'h01, 8'h00, 32'h0, 1'b0);
      ok(act_pos, 1'b1);
      check("accu", accu, act_pos);
      standalone <= 1'b0;
      cmd(8'h01, 8'h06, 8'h05, 8'h00, 32'h0, 1'b0);
      ok(axis_data, 1'b1);
      check("axis_sel", {24'h0, axis_sel}, 32'h05);
      check("accu", accu, act_pos);
      v = rnd();
      cmd(8'h01, 8'h09, 8'h2A, 8'h02, v, 1'b0);
      cmd(8'h01, 8'h0B, 8'h2A, 8'h02, 32'h0, 1'b0);
      ok(32'h0, 1'b1);
      cmd(8'h01, 8'h09, 8'h2A, 8'h02, ~v, 1'b0);
      cmd(8'h01, 8'h0C, 8'h2A, 8'h02, 32'h0, 1'b0);
      ok(32'h0, 1'b1);
      cmd(8'h01, 8'h0A, 8'h2A, 8'h02, 32'h0, 1'b0);
      ok(v, 1'b1);
      cmd(8'h01, 8'h09, 8'h2A, 8'h02, ~v, 1'b0);
      do_reset();
      cmd(8'h01, 8'h0A, 8'h2A, 8'h02, 32'h0, 1'b0);
      ok(v, 1'b1);
      cmd(8'h01, 8'h09, 8'h05, 8'h01, v, 1'b0);
      check("status", {24'h0, st}, 32'h04);
      cmd(8'h01, 8'h06, 8'h01, 8'h01, 32'h0, 1'b0);
      check("status", {24'h0, st}, 32'h04);
      cmd(8'h01, 8'h0B, 8'h2A, 8'h00, 32'h0, 1'b0);
      check("status", {24'h0, st}, 32'h04);
      cmd(8'h01, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b1);
      check("reply", {31'h0, g}, 32'h0);
      cmd(8'h01, 8'h09, 8'h42, 8'h00, 32'h3, 1'b0);
      check("address", {24'h0, ser_addr}, 32'h3);
      cmd(8'h01, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0);
      check("reply", {31'h0, g}, 32'h0);
      cmd(8'h03, 8'h0A, 8'h42, 8'h00, 32'h0, 1'b0);
      ok(32'h3, 1'b1);
      give_verdict();
   end
endmodule // pac_decoder_tb_top
`default_nettype wire
